// ===== design/fcoc_div.sv
// Iterative restoring divider, one quotient bit per cycle
`timescale 1ns/100ps
module fcoc_div #(
  parameter int DW = 24,
  parameter int VW = 16
) (
  // Clock and control
  input  wire logic          clock,
  input  wire logic          srst,
  input  wire logic          ce,
  input  wire logic          start,
  // Operands
  input  wire logic [DW-1:0] dividend,
  input  wire logic [VW-1:0] divisor,
  // Results
  output logic      [DW-1:0] quotient,
  output logic      [VW-1:0] remainder,
  output logic               done
);
  localparam int CW = $clog2(DW + 1);
  logic [DW-1:0] quo_ff, nxt_quo;
  logic [VW:0]   rem_ff, nxt_rem, trial;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic          done_ff, nxt_done;

  // Shift one dividend bit in and try a subtraction
  always_comb begin
    nxt_quo  = quo_ff;
    nxt_rem  = rem_ff;
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    trial    = {rem_ff[VW-1:0], quo_ff[DW-1]};
    if (start) begin
      nxt_quo = dividend;
      nxt_rem = '0;
      nxt_cnt = CW'(DW);
    end else if (cnt_ff != '0) begin
      if (trial >= {1'b0, divisor}) begin
        nxt_rem = trial - {1'b0, divisor};
        nxt_quo = {quo_ff[DW-2:0], 1'b1};
      end else begin
        nxt_rem = trial;
        nxt_quo = {quo_ff[DW-2:0], 1'b0};
      end
      nxt_cnt  = cnt_ff - 1'b1;
      nxt_done = (cnt_ff == CW'(1));
    end
  end

  // State registers, frozen while clock enable and reset are both low
  always_ff @(posedge clock) begin
    if (srst) begin
      quo_ff  <= '0;
      rem_ff  <= '0;
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else if (ce) begin
      quo_ff  <= nxt_quo;
      rem_ff  <= nxt_rem;
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign quotient  = quo_ff;
  assign remainder = rem_ff[VW-1:0];
  assign done      = done_ff;
endmodule

// ===== design/fcoc_pkg.sv
// Constants, register map and command codes of the frame/chip offset calculator
// ----------------------------------------------------------------------------
// Behaviour
// R1: Common-state frame offset is always zero
// R2: Single FDD link: offset equals default times 512
// R3: Single TDD link: frame offset equals TDD default
// R4: TDD common channels keep zero frame offset
// R5: Several FDD links add cell frame and chip
// R6: New link: offset from target differences only
// R7: Unknown target in hard handover uses single formula
// R8: TDD target: known difference, else TDD default
// R9: TDD arrival from other network: difference zero
// R10: Common init: paging full, others modulo 256
// R11: Common counters advance each frame, paging wider
// R12: FDD single link counter init by quotient formula
// R13: TDD single link counter init minus default
// R14: Dedicated counter advances by one per frame
// R15: TDD common counter stays system number mod 256
// R16: Base station rounds to 256-chip boundary
// R17: Configuration bit selects the plus-256 variant
// R18: Several FDD links use reference cell counter init
// ----------------------------------------------------------------------------
package fcoc_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DOFF = 8'h04;
  localparam logic [7:0] ADDR_SFN  = 8'h08;
  localparam logic [7:0] ADDR_CELL = 8'h0c;
  localparam logic [7:0] ADDR_CMD  = 8'h10;
  localparam logic [7:0] ADDR_RES  = 8'h14;
  localparam logic [7:0] ADDR_CFN  = 8'h18;
  // Control bit positions
  localparam int CTRL_TDD   = 0;
  localparam int CTRL_V256  = 1;
  localparam int CTRL_DCH   = 2;
  localparam int CTRL_KNOWN = 3;
  localparam int CTRL_HARD  = 4;
  localparam int CTRL_OTHER = 5;
  localparam int CTRL_W     = 6;
  // Field widths and positions
  localparam int FDD_W    = 10;
  localparam int TDD_W    = 7;
  localparam int SFN_W    = 12;
  localparam int FO_W     = 8;
  localparam int CHIP_W   = 16;
  localparam int DVD_W    = 24;
  localparam int DOFT_LSB = 16;
  localparam int TM_LSB   = 16;
  localparam int CHIP_LSB = 16;
  localparam int DCH_LSB  = 8;
  localparam int PCH_LSB  = 16;
  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;
  localparam logic [31:0]       WORD_RST = 32'h0000_0000;
  // Timing arithmetic
  localparam int CHIPS_PER_FRAME = 38400;
  localparam int DOFF_SHIFT      = 9;
  localparam int DOFF_SCALE      = 512;
  localparam int VARIANT_CHIPS   = 256;
  localparam int FRAME_WRAP      = 9830400;
  // Command codes written to the command register
  localparam logic [2:0] CMD_SINGLE  = 3'h0;
  localparam logic [2:0] CMD_MULTI   = 3'h1;
  localparam logic [2:0] CMD_TARGET  = 3'h2;
  localparam logic [2:0] CMD_CFN_COM = 3'h3;
  localparam logic [2:0] CMD_CFN_DCH = 3'h4;
  // Sequencer states
  typedef enum logic {FC_IDLE, FC_BUSY} fcoc_st_t;
endpackage

// ===== design/fcoc_top.sv
// Frame/chip offset and connection frame counter calculator, AHB-Lite slave
`timescale 1ns/100ps
module fcoc_top (
  // Clock, reset, enable
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        ce,
  // Frame tick
  input  wire logic        frame_tick,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // Offsets toward the base station
  output logic      [7:0]  frame_offset,
  output logic      [15:0] chip_offset,
  output logic             offset_valid,
  // Frame counters and status
  output logic      [7:0]  cfn_common,
  output logic      [7:0]  cfn_dedicated,
  output logic      [11:0] cfn_paging,
  output logic             busy
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [fcoc_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [fcoc_pkg::FDD_W-1:0]  default_offset_freq_division_ff, nxt_default_offset_freq_division;
  logic [fcoc_pkg::TDD_W-1:0]  default_offset_time_division_ff, nxt_default_offset_time_division;
  logic [fcoc_pkg::SFN_W-1:0]  sfn_ff, nxt_sfn;
  logic [7:0]                  off_ff, nxt_off;
  logic [15:0]                 tm_ff, nxt_tm;
  logic                        wph_ff, nxt_wph;
  logic [7:0]                  wadr_ff, nxt_wadr;
  logic [31:0]                 hrdata_ff, nxt_hrdata, rd_val;
  logic                        acc, cfg_wr, cmd_go;
  logic [2:0]                  cmd_kind;
  fcoc_pkg::fcoc_st_t          st_ff, nxt_st;
  logic [2:0]                  kind_ff, nxt_kind;
  logic [7:0]                  fo_ff, nxt_fo;
  logic [15:0]                 chip_ff, nxt_chip;
  logic                        valid_ff, nxt_valid;
  logic [7:0]                  com_ff, nxt_com;
  logic [7:0]                  dch_ff, nxt_dch;
  logic [11:0]                 pch_ff, nxt_pch;
  logic                        div_go, div_done;
  logic [23:0]                 div_dvd, div_quo;
  logic [15:0]                 div_rem;
  logic [23:0]                 base_chips, cell_chips;
  logic [7:0]                  off_eff;
  logic                        tdd, dch, v256;

  assign tdd  = ctrl_ff[fcoc_pkg::CTRL_TDD];
  assign dch  = ctrl_ff[fcoc_pkg::CTRL_DCH];
  assign v256 = ctrl_ff[fcoc_pkg::CTRL_V256];

  // ----------------------------------------------------------------------
  // AHB-Lite slave and configuration registers
  // ----------------------------------------------------------------------
  // Valid single-word transfer in address phase
  assign acc = hsel && hready && htrans[1] && (hsize == 3'h2);
  // Config writes are ignored while a computation runs
  assign cfg_wr   = wph_ff && (st_ff == fcoc_pkg::FC_IDLE);
  assign cmd_go   = cfg_wr && (wadr_ff == fcoc_pkg::ADDR_CMD);
  assign cmd_kind = hwdata[2:0];

  // Read multiplexer, unmapped addresses read zero
  always_comb begin
    rd_val = fcoc_pkg::WORD_RST;
    case (haddr[7:0])
      fcoc_pkg::ADDR_CTRL: rd_val = {26'h0, ctrl_ff};
      fcoc_pkg::ADDR_DOFF: rd_val = {9'h0, default_offset_time_division_ff, 6'h0, default_offset_freq_division_ff};
      fcoc_pkg::ADDR_SFN:  rd_val = {20'h0, sfn_ff};
      fcoc_pkg::ADDR_CELL: rd_val = {tm_ff, 8'h0, off_ff};
      fcoc_pkg::ADDR_CMD:  rd_val = {31'h0, st_ff == fcoc_pkg::FC_BUSY};
      fcoc_pkg::ADDR_RES:  rd_val = {chip_ff, 8'h0, fo_ff};
      fcoc_pkg::ADDR_CFN:  rd_val = {4'h0, pch_ff, dch_ff, com_ff};
      default:             rd_val = fcoc_pkg::WORD_RST;
    endcase
  end

  // Next values of bus phase and configuration registers
  always_comb begin
    nxt_wph      = acc && hwrite;
    nxt_wadr     = acc ? haddr[7:0] : wadr_ff;
    nxt_hrdata   = (acc && !hwrite) ? rd_val : hrdata_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_default_offset_freq_division = default_offset_freq_division_ff;
    nxt_default_offset_time_division = default_offset_time_division_ff;
    nxt_sfn      = sfn_ff;
    nxt_off      = off_ff;
    nxt_tm       = tm_ff;
    if (cfg_wr) begin
      case (wadr_ff)
        fcoc_pkg::ADDR_CTRL: nxt_ctrl = hwdata[fcoc_pkg::CTRL_W-1:0];
        fcoc_pkg::ADDR_DOFF: begin
          nxt_default_offset_freq_division = hwdata[fcoc_pkg::FDD_W-1:0];
          nxt_default_offset_time_division = hwdata[fcoc_pkg::DOFT_LSB +: fcoc_pkg::TDD_W];
        end
        fcoc_pkg::ADDR_SFN:  nxt_sfn = hwdata[fcoc_pkg::SFN_W-1:0];
        fcoc_pkg::ADDR_CELL: begin
          nxt_off = hwdata[7:0];
          nxt_tm  = hwdata[fcoc_pkg::TM_LSB +: 16];
        end
        default: ;
      endcase
    end
  end

  // Bus and configuration registers
  always_ff @(posedge clock) begin
    if (srst) begin
      wph_ff      <= 1'b0;
      wadr_ff     <= 8'h00;
      hrdata_ff   <= fcoc_pkg::WORD_RST;
      ctrl_ff     <= fcoc_pkg::CTRL_RST;
      default_offset_freq_division_ff <= '0;
      default_offset_time_division_ff <= '0;
      sfn_ff      <= '0;
      off_ff      <= 8'h00;
      tm_ff       <= 16'h0000;
    end else if (ce) begin
      wph_ff      <= nxt_wph;
      wadr_ff     <= nxt_wadr;
      hrdata_ff   <= nxt_hrdata;
      ctrl_ff     <= nxt_ctrl;
      default_offset_freq_division_ff <= nxt_default_offset_freq_division;
      default_offset_time_division_ff <= nxt_default_offset_time_division;
      sfn_ff      <= nxt_sfn;
      off_ff      <= nxt_off;
      tm_ff       <= nxt_tm;
    end
  end

  // ----------------------------------------------------------------------
  // Offset arithmetic and frame counters
  // ----------------------------------------------------------------------
  // Default offset in chips plus the optional 256-chip variant
  assign base_chips = {5'h00, default_offset_freq_division_ff, 9'h000}
                    + (v256 ? 24'h000100 : 24'h000000); // R2 R17
  // Cell frame and chip difference in chips
  assign cell_chips = 24'(off_ff) * 24'(fcoc_pkg::CHIPS_PER_FRAME) + 24'(tm_ff);
  // TDD arrival from another network counts as zero difference
  assign off_eff = (tdd && ctrl_ff[fcoc_pkg::CTRL_OTHER]) ? 8'h00 : off_ff; // R9

  // Sequencer, results and counters
  always_comb begin
    nxt_st    = st_ff;
    nxt_kind  = kind_ff;
    nxt_fo    = fo_ff;
    nxt_chip  = chip_ff;
    nxt_valid = 1'b0;
    nxt_com   = com_ff;
    nxt_dch   = dch_ff;
    nxt_pch   = pch_ff;
    div_go    = 1'b0;
    div_dvd   = base_chips;
    if (frame_tick) begin
      nxt_com = com_ff + 8'h01;   // R11
      nxt_pch = pch_ff + 12'h001; // R11
      nxt_dch = dch_ff + 8'h01;   // R14
    end
    case (st_ff)
      fcoc_pkg::FC_IDLE: begin
        if (cmd_go) begin
          nxt_kind = cmd_kind;
          case (cmd_kind)
            fcoc_pkg::CMD_CFN_COM: begin
              nxt_pch = sfn_ff;      // R10
              nxt_com = sfn_ff[7:0]; // R10
            end
            fcoc_pkg::CMD_CFN_DCH: begin
              if (tdd) begin
                nxt_dch = sfn_ff[7:0] - 8'(default_offset_time_division_ff); // R13
                nxt_com = sfn_ff[7:0];                   // R15
              end else begin
                div_dvd = {5'h00, default_offset_freq_division_ff, 9'h000}; // R12 R18
                div_go  = 1'b1;
                nxt_st  = fcoc_pkg::FC_BUSY;
              end
            end
            fcoc_pkg::CMD_SINGLE, fcoc_pkg::CMD_MULTI, fcoc_pkg::CMD_TARGET: begin
              if (!dch) begin
                // Common and shared channels carry no offset
                nxt_fo    = 8'h00;    // R1 R4
                nxt_chip  = 16'h0000; // R1
                nxt_valid = 1'b1;
              end else if (tdd) begin
                if (cmd_kind == fcoc_pkg::CMD_TARGET && ctrl_ff[fcoc_pkg::CTRL_KNOWN]) begin
                  nxt_fo = off_eff;            // R8
                end else begin
                  nxt_fo = 8'(default_offset_time_division_ff);    // R3 R8
                end
                nxt_chip  = 16'h0000;
                nxt_valid = 1'b1;
              end else begin
                if (cmd_kind == fcoc_pkg::CMD_MULTI) begin
                  div_dvd = base_chips + cell_chips; // R5
                end else if (cmd_kind == fcoc_pkg::CMD_TARGET) begin
                  if (ctrl_ff[fcoc_pkg::CTRL_HARD] && !ctrl_ff[fcoc_pkg::CTRL_KNOWN]) begin
                    div_dvd = base_chips;            // R7
                  end else begin
                    div_dvd = cell_chips;            // R6
                  end
                end else begin
                  div_dvd = base_chips;              // R2
                end
                div_go = 1'b1;
                nxt_st = fcoc_pkg::FC_BUSY;
              end
            end
            default: ;
          endcase
        end
      end
      fcoc_pkg::FC_BUSY: begin
        if (div_done) begin
          nxt_st = fcoc_pkg::FC_IDLE;
          if (kind_ff == fcoc_pkg::CMD_CFN_DCH) begin
            nxt_dch = sfn_ff[7:0] - div_quo[7:0]; // R12 R18
          end else begin
            // Frame count wraps modulo 256, chips are the remainder
            nxt_fo    = div_quo[7:0];
            nxt_chip  = div_rem;
            nxt_valid = 1'b1;
          end
        end
      end
      default: nxt_st = fcoc_pkg::FC_IDLE;
    endcase
  end

  // Sequencer and counter registers
  always_ff @(posedge clock) begin
    if (srst) begin
      st_ff    <= fcoc_pkg::FC_IDLE;
      kind_ff  <= fcoc_pkg::CMD_SINGLE;
      fo_ff    <= 8'h00;
      chip_ff  <= 16'h0000;
      valid_ff <= 1'b0;
      com_ff   <= 8'h00;
      dch_ff   <= 8'h00;
      pch_ff   <= 12'h000;
    end else if (ce) begin
      st_ff    <= nxt_st;
      kind_ff  <= nxt_kind;
      fo_ff    <= nxt_fo;
      chip_ff  <= nxt_chip;
      valid_ff <= nxt_valid;
      com_ff   <= nxt_com;
      dch_ff   <= nxt_dch;
      pch_ff   <= nxt_pch;
    end
  end

  // Divide by one frame of chips
  fcoc_div #(.DW(24), .VW(16)) u_div (
    .clock     (clock),
    .srst      (srst),
    .ce        (ce),
    .start     (div_go),
    .dividend  (div_dvd),
    .divisor   (16'(fcoc_pkg::CHIPS_PER_FRAME)),
    .quotient  (div_quo),
    .remainder (div_rem),
    .done      (div_done)
  );

  // Outputs from registers, hreadyout and hresp tied to ready and okay
  assign hreadyout     = 1'b1 | srst;
  assign hresp         = 1'b0 & srst;
  assign hrdata        = hrdata_ff;
  assign frame_offset  = fo_ff;
  assign chip_offset   = chip_ff;
  assign offset_valid  = valid_ff;
  assign cfn_common    = com_ff;
  assign cfn_dedicated = dch_ff;
  assign cfn_paging    = pch_ff;
  assign busy          = (st_ff == fcoc_pkg::FC_BUSY);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  int got_chips, exp_base, exp_cell, exp_fdd_cfn;
  always_comb begin
    got_chips   = int'(fo_ff) * fcoc_pkg::CHIPS_PER_FRAME + int'(chip_ff);
    exp_base    = int'(default_offset_freq_division_ff) * fcoc_pkg::DOFF_SCALE
                + (v256 ? fcoc_pkg::VARIANT_CHIPS : 0);
    exp_cell    = int'(off_ff) * fcoc_pkg::CHIPS_PER_FRAME + int'(tm_ff);
    exp_fdd_cfn = (int'(sfn_ff) + 256
                - (int'(default_offset_freq_division_ff) * fcoc_pkg::DOFF_SCALE)
                  / fcoc_pkg::CHIPS_PER_FRAME) % 256;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  property p_common_zero;
    valid_ff && !dch |-> fo_ff == 8'h00 && chip_ff == 16'h0000;
  endproperty
  a_common_zero: assert property (p_common_zero) else $error("offset not zero"); // R1

  property p_fdd_single;
    valid_ff && dch && !tdd && kind_ff == fcoc_pkg::CMD_SINGLE
      |-> got_chips == exp_base;
  endproperty
  a_fdd_single: assert property (p_fdd_single) else $error("single offset wrong"); // R2

  property p_tdd_single;
    valid_ff && dch && tdd && kind_ff == fcoc_pkg::CMD_SINGLE
      |-> fo_ff == 8'(default_offset_time_division_ff);
  endproperty
  a_tdd_single: assert property (p_tdd_single) else $error("tdd offset wrong"); // R3

  property p_fdd_multi;
    valid_ff && dch && !tdd && kind_ff == fcoc_pkg::CMD_MULTI
      |-> got_chips == (exp_base + exp_cell) % fcoc_pkg::FRAME_WRAP;
  endproperty
  a_fdd_multi: assert property (p_fdd_multi) else $error("multi offset wrong"); // R5

  property p_fdd_target;
    valid_ff && dch && !tdd && kind_ff == fcoc_pkg::CMD_TARGET
      |-> got_chips == ((ctrl_ff[fcoc_pkg::CTRL_HARD] && !ctrl_ff[fcoc_pkg::CTRL_KNOWN])
                        ? exp_base : exp_cell % fcoc_pkg::FRAME_WRAP);
  endproperty
  a_fdd_target: assert property (p_fdd_target) else $error("target offset wrong"); // R6

  property p_com_init;
    ce && cmd_go && cmd_kind == fcoc_pkg::CMD_CFN_COM
      |=> pch_ff == $past(sfn_ff) && com_ff == $past(sfn_ff[7:0]);
  endproperty
  a_com_init: assert property (p_com_init) else $error("common init wrong"); // R10

  property p_com_adv;
    ce && frame_tick && !cmd_go |=> com_ff == $past(com_ff) + 8'h01;
  endproperty
  a_com_adv: assert property (p_com_adv) else $error("common count stuck"); // R11

  property p_fdd_cfn;
    ce && st_ff == fcoc_pkg::FC_BUSY && div_done && kind_ff == fcoc_pkg::CMD_CFN_DCH
      |=> int'(dch_ff) == exp_fdd_cfn;
  endproperty
  a_fdd_cfn: assert property (p_fdd_cfn) else $error("fdd counter init wrong"); // R12

  property p_tdd_cfn;
    ce && cmd_go && cmd_kind == fcoc_pkg::CMD_CFN_DCH && tdd
      |=> dch_ff == $past(sfn_ff[7:0]) - 8'($past(default_offset_time_division_ff)) && com_ff == sfn_ff[7:0];
  endproperty
  a_tdd_cfn: assert property (p_tdd_cfn) else $error("tdd counter init wrong"); // R13

  property p_dch_adv;
    ce && frame_tick && !cmd_go && !div_done |=> dch_ff == $past(dch_ff) + 8'h01;
  endproperty
  a_dch_adv: assert property (p_dch_adv) else $error("dedicated count stuck"); // R14

  c_single: cover property (valid_ff && dch && !tdd && kind_ff == fcoc_pkg::CMD_SINGLE);
  c_multi:  cover property (valid_ff && dch && !tdd && kind_ff == fcoc_pkg::CMD_MULTI);
  c_cfn:    cover property (div_done && kind_ff == fcoc_pkg::CMD_CFN_DCH);
  c_tdd:    cover property (valid_ff && tdd && dch);
endmodule

// ===== verif/fcoc_bs_model.sv
// Base station model: rounds each delivered offset pair to 256 chips
`timescale 1ns/100ps
module fcoc_bs_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Offsets from the calculator
  input  wire logic [7:0]  frame_offset,
  input  wire logic [15:0] chip_offset,
  input  wire logic        offset_valid,
  // Rounded downlink timing in chips
  output logic      [31:0] dl_timing
);
  // Latch and round on every delivered pair
  always_ff @(posedge clock) begin
    if (srst)
      dl_timing <= 32'h0;
    else if (offset_valid)
      dl_timing <= ((frame_offset * 32'h9600 + chip_offset + 32'h80) >> 8) << 8;
  end
endmodule

// ===== verif/tb_top.sv
// Self-checking testbench of the frame/chip offset calculator
`timescale 1ns/100ps
module tb_top;
  // ----------------------------------------------------------------
  // Signals and stimulus values
  // ----------------------------------------------------------------
  localparam int DOFF_F = 32'h3ff;
  localparam int DOFF_T = 32'h45;
  localparam int OFF    = 32'hfe;
  localparam int TM     = 32'h95ff;
  localparam logic [8:0] CASES [15] = '{
    9'h000, 9'h001, 9'h002, 9'h008,
    9'h020, 9'h030, 9'h021, 9'h031,
    9'h062, 9'h0a2, 9'h0b2,
    9'h028, 9'h06a, 9'h02a, 9'h16a};
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        frame_tick = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire         hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [7:0]  frame_offset;
  logic [15:0] chip_offset;
  logic        offset_valid;
  logic [7:0]  cfn_common;
  logic [7:0]  cfn_dedicated;
  logic [11:0] cfn_paging;
  logic        busy;
  logic [31:0] dl_timing;
  logic [31:0] rd;
  logic [5:0]  ctrl;
  logic [7:0]  cap_fo;
  logic [15:0] cap_co;
  logic [7:0]  e_com;
  logic [7:0]  e_ded;
  logic [11:0] e_pag;
  int          n_errors = 0;
  int          n_tests = 0;
  int          n_valid = 0;

  assign hready = hreadyout;
  always #4 clock = ~clock;

  fcoc_top dut (.clock, .srst, .ce(1'b1), .frame_tick, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .frame_offset, .chip_offset,
    .offset_valid, .cfn_common, .cfn_dedicated, .cfn_paging, .busy);
  fcoc_bs_model bs (.clock, .srst, .frame_offset, .chip_offset, .offset_valid, .dl_timing);

  // Capture each one-cycle result pulse
  always @(posedge clock) begin
    if (offset_valid === 1'b1) begin
      cap_fo <= frame_offset;
      cap_co <= chip_offset;
      n_valid <= n_valid + 1;
    end
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  // One single word transfer; read data lands in rd
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Issue a command, then poll busy until it drops
  task automatic run(input logic [2:0] c);
    int i;
    bus(fcoc_pkg::ADDR_CMD, 1'b1, {29'h0, c});
    repeat (2) @(posedge clock);
    rd = 32'h1;
    for (i = 0; i < 40 && rd[0] !== 1'b0; i++)
      bus(fcoc_pkg::ADDR_CMD, 1'b0, 32'h0);
    chk("busy_done", 32'h0, {30'h0, hresp, busy});
  endtask

  task automatic tick(input int n);
    repeat (n) begin
      frame_tick <= 1'b1;
      @(posedge clock);
      frame_tick <= 1'b0;
      @(posedge clock);
      e_com++;
      e_ded++;
      e_pag++;
    end
  endtask

  task automatic cfn_chk();
    bus(fcoc_pkg::ADDR_CFN, 1'b0, 32'h0);
    chk("cfn_reg", {4'h0, e_pag, e_ded, e_com}, rd);
    chk("cfn_ports", {4'h0, e_pag, e_ded, e_com}, {4'h0, cfn_paging, cfn_dedicated, cfn_common});
  endtask

  // Expected result word: chip offset high, frame offset low
  function automatic logic [31:0] exp_res(input logic [2:0] c);
    int t;
    t = DOFF_F * fcoc_pkg::DOFF_SCALE + (ctrl[1] ? fcoc_pkg::VARIANT_CHIPS : 0);
    if (c == 3'h1)
      t = t + OFF * fcoc_pkg::CHIPS_PER_FRAME + TM;
    if (c == 3'h2 && !(ctrl[4] && !ctrl[3]))
      t = OFF * fcoc_pkg::CHIPS_PER_FRAME + TM;
    if (!ctrl[2])
      t = 0;
    else if (ctrl[0])
      t = ((c == 3'h2 && ctrl[3]) ? (ctrl[5] ? 0 : OFF) : DOFF_T) * fcoc_pkg::CHIPS_PER_FRAME;
    return {16'(t % fcoc_pkg::CHIPS_PER_FRAME), 8'h0, 8'(t / fcoc_pkg::CHIPS_PER_FRAME)};
  endfunction

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] e;
    int          nv;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    bus(fcoc_pkg::ADDR_CTRL, 1'b0, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    chk("out_reset", 32'h0, {frame_offset, chip_offset, cfn_common});
    bus(fcoc_pkg::ADDR_DOFF, 1'b1, {9'h0, DOFF_T[6:0], 6'h0, DOFF_F[9:0]});
    bus(fcoc_pkg::ADDR_CELL, 1'b1, {TM[15:0], 8'h0, OFF[7:0]});
    bus(fcoc_pkg::ADDR_SFN, 1'b1, 32'h0000_0ffe);
    // Every FDD offset computation mode, TDD single and target only
    for (int k = 0; k < 15; k++) begin
      ctrl = CASES[k][8:3];
      nv = n_valid;
      bus(fcoc_pkg::ADDR_CTRL, 1'b1, {26'h0, ctrl});
      run(CASES[k][2:0]);
      e = exp_res(CASES[k][2:0]);
      bus(fcoc_pkg::ADDR_RES, 1'b0, 32'h0);
      chk("res_reg", e, rd);
      chk("res_ports", e, {cap_co, 8'h0, cap_fo});
      chk("valid_count", 32'(nv + 1), 32'(n_valid));
      chk("dl_timing", ((e[7:0] * 32'h9600 + e[31:16] + 32'h80) >> 8) << 8, dl_timing);
    end
    // Read-only and busy-time writes are dropped, unmapped reads return zero
    bus(fcoc_pkg::ADDR_RES, 1'b1, 32'hffff_ffff);
    bus(fcoc_pkg::ADDR_RES, 1'b0, 32'h0);
    chk("res_ro", e, rd);
    bus(8'h1c, 1'b0, 32'h0);
    chk("unmapped", 32'h0, rd);
    ctrl = 6'h04;
    bus(fcoc_pkg::ADDR_CTRL, 1'b1, {26'h0, ctrl});
    bus(fcoc_pkg::ADDR_CMD, 1'b1, 32'h0);
    bus(fcoc_pkg::ADDR_DOFF, 1'b1, 32'h0);
    run(3'h5);
    bus(fcoc_pkg::ADDR_DOFF, 1'b0, 32'h0);
    chk("doff_busy", {9'h0, DOFF_T[6:0], 6'h0, DOFF_F[9:0]}, rd);
    // Counter init and advance with wrap of the common and paging counters
    ctrl = 6'h00;
    bus(fcoc_pkg::ADDR_CTRL, 1'b1, 32'h0);
    run(fcoc_pkg::CMD_CFN_COM);
    e_pag = 12'hffe;
    e_com = 8'hfe;
    e_ded = 8'h00;
    cfn_chk();
    tick(3);
    cfn_chk();
    bus(fcoc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0005);
    run(fcoc_pkg::CMD_CFN_DCH);
    e_ded = 8'(32'hffe - DOFF_T);
    e_com = 8'hfe;
    cfn_chk();
    tick(2);
    cfn_chk();
    bus(fcoc_pkg::ADDR_CTRL, 1'b1, 32'h0000_0004);
    run(fcoc_pkg::CMD_CFN_DCH);
    e_ded = 8'(32'hffe - (DOFF_F * fcoc_pkg::DOFF_SCALE) / fcoc_pkg::CHIPS_PER_FRAME);
    cfn_chk();
    tick(2);
    cfn_chk();
    test_done();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (8000) @(posedge clock);
    n_errors++;
    test_done();
  end
endmodule
